// ===== pkg/svw_pkg.sv
// Purpose: Shared constants for the supervisor watchdog and takeover core.
// Assumes: One system clock at 200 MHz; the noise, period and hold times are converted to cycles.
// Notes: Times stay in their own units; cycle counts are derived from them.
package svw_pkg;

  // System clock period in picoseconds (200 MHz).
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Kick pulses narrower than this are noise, wider ones are kicks.
  localparam int unsigned KICK_NOISE_NS = 1000;
  localparam int unsigned KICK_VALID_NS = 6500;

  // A level must hold for the noise time, rounded up to whole cycles.
  localparam int unsigned KICK_FILT_CYC =
    (KICK_NOISE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Default watchdog timeout period and reset hold time, in nanoseconds.
  localparam longint unsigned WD_PERIOD_NS = 64'd12000000;
  localparam longint unsigned RESET_HOLD_NS = 64'd12000000;

  // Longest times round down to whole cycles.
  localparam longint unsigned WD_PERIOD_CYC =
    (WD_PERIOD_NS * 64'd1000) / CLK_PERIOD_PS;
  localparam longint unsigned RESET_HOLD_CYC =
    (RESET_HOLD_NS * 64'd1000) / CLK_PERIOD_PS;

  // Closed window sizes, as a percentage of the timeout period.
  localparam int unsigned WIN_PCT_HALF = 50;
  localparam int unsigned WIN_PCT_THREE_QUARTER = 75;
  localparam int unsigned PCT_FULL = 100;

  // Consecutive misses that raise takeover, and good kicks that drop it.
  localparam int unsigned TAKE_MISSES = 3;
  localparam int unsigned TAKE_GOOD_KICKS = 3;

  // Width of the watchdog and reset hold counters.
  localparam int unsigned CNT_WIDTH = 32;

  // Width of the small event counters.
  localparam int unsigned EVT_WIDTH = 2;

  // Idle level of the kick line before the first filtered value.
  localparam logic KICK_IDLE = 1'h1;

  // Takeover output states.
  typedef enum logic [0:0] {
    SVW_TK_CLEAR = 1'b0,
    SVW_TK_ASSERTED = 1'b1
  } svw_take_state_t;

  // Reset output states.
  typedef enum logic [0:0] {
    SVW_RS_RELEASED = 1'b0,
    SVW_RS_HOLD = 1'b1
  } svw_rst_state_t;

endpackage

// ===== src/svw_kick_filter.sv
// Purpose: Synchronise the kick pin, reject narrow pulses, flag falls.
// Assumes: Kick pin is asynchronous to i_clk and always driven.
// Notes: A new level is accepted only after it held for FILT_CYC cycles.
`timescale 1ns/100ps
module svw_kick_filter #(
  parameter int unsigned FILT_CYC = svw_pkg::KICK_FILT_CYC,
  parameter int unsigned FW = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_kick,
  output logic o_fall
);

  localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYC - 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic stable;
    logic [FW-1:0] cnt;
    logic fall;
  } svw_filt_t;

  svw_filt_t st_q;
  svw_filt_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = i_kick; // [R16]
    st_d.s2 = st_q.s1; // [R16]
    st_d.fall = 1'b0;
    // A differing level that does not last the full count is dropped.
    if (st_q.s2 != st_q.stable) begin
      if (st_q.cnt == FILT_LAST) begin // [R13]
        st_d.stable = st_q.s2;
        st_d.fall = st_q.stable & ~st_q.s2;
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + FW'(1);
      end
    end else begin
      st_d.cnt = '0; // [R13]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q <= '{s1: svw_pkg::KICK_IDLE, s2: svw_pkg::KICK_IDLE,
                stable: svw_pkg::KICK_IDLE, cnt: '0, fall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_fall = st_q.fall;

endmodule

// ===== src/svw_core.sv
// Purpose: Watchdog, reset hold timer and takeover flag of a supervisor.
// Assumes: Comparator results arrive as asynchronous logic levels.
// Notes: All timing is in system clock cycles; reset and takeover outputs are active low, the fault flag is active high.
`timescale 1ns/100ps
// What this block does
// R1 - Timeout mode: kick each period or reset
// R2 - Watchdog timer clears on kick or reset
// R3 - Three unkicked periods drive takeover low
// R4 - Takeover released after three good kicks
// R5 - No takeover while either level is low
// R6 - Window mode: early or late kick resets
// R7 - Window timer starts from zero after release
// R8 - Reset asserted while supervised level is low
// R9 - Reset held further hold time after recovery
// R10 - Faults give exact hold-time pulse, then release
// R11 - Disable setting suppresses all watchdog action
// R12 - Controller always drives the kick input
// R13 - Kick pulses under noise width are ignored
// R14 - Closed window is 50 or 75 percent
// R15 - Period and hold time are cycle counts
// R16 - Kick synchronised; outputs registered, reset and takeover active low
module svw_core #(
  parameter longint unsigned WD_CYCLES = svw_pkg::WD_PERIOD_CYC,
  parameter longint unsigned HOLD_CYCLES = svw_pkg::RESET_HOLD_CYC,
  parameter int unsigned WINDOW_PCT = svw_pkg::WIN_PCT_HALF,
  parameter int unsigned FILT_CYC = svw_pkg::KICK_FILT_CYC,
  parameter int unsigned CW = svw_pkg::CNT_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_watchdog_kick_in,
  input wire logic i_supervised_level_in,
  input wire logic i_gate_level_in,
  input wire logic i_window_mode,
  input wire logic i_wdog_disable,
  output logic o_reset_n,
  output logic o_takeover_n,
  output logic o_wdog_fault
);

  localparam int unsigned EW = svw_pkg::EVT_WIDTH;

  // The closed window is a fixed fraction of the period. [R14]
  localparam longint unsigned WIN_CYCLES =
    (WD_CYCLES * WINDOW_PCT) / svw_pkg::PCT_FULL;

  // Counts are compared with the value reached at their last cycle, the window count with its first open value. [R15]
  localparam logic [CW-1:0] WD_LAST = CW'(WD_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] WIN_OPEN = CW'(WIN_CYCLES);
  localparam logic [EW-1:0] MISS_LAST = EW'(svw_pkg::TAKE_MISSES - 1);
  localparam logic [EW-1:0] GOOD_LAST = EW'(svw_pkg::TAKE_GOOD_KICKS - 1);

  typedef struct packed {
    logic lvl_s1;
    logic lvl_s2;
    logic gate_s1;
    logic gate_s2;
    svw_pkg::svw_rst_state_t rst;
    logic [CW-1:0] hold_cnt;
    logic [CW-1:0] wd_cnt;
    logic [EW-1:0] miss_cnt;
    logic [EW-1:0] good_cnt;
    svw_pkg::svw_take_state_t take;
    logic fault;
  } svw_state_t;

  svw_state_t st_q;
  svw_state_t st_d;
  logic kick_fall;

  // Early kick test, used by fault and good-kick decisions.
  function automatic logic kick_is_early(input logic win,
                                         input logic [CW-1:0] cnt);
    kick_is_early = win && (cnt < WIN_OPEN);
  endfunction

  svw_kick_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_kick_filter (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_kick(i_watchdog_kick_in), // [R12]
    .o_fall(kick_fall)
  );

  logic lvl_ok;
  logic gate_ok;
  logic wd_run;
  logic expired;
  logic early;
  logic good_kick;
  logic fault_now;

  always_comb begin
    lvl_ok = st_q.lvl_s2;
    gate_ok = st_q.gate_s2;
    // The watchdog only times while reset is released and it is enabled.
    wd_run = (st_q.rst == svw_pkg::SVW_RS_RELEASED) && !i_wdog_disable;
    expired = wd_run && !kick_fall && (st_q.wd_cnt == WD_LAST); // [R1]
    early = wd_run && kick_fall &&
            kick_is_early(i_window_mode, st_q.wd_cnt); // [R6]
    good_kick = wd_run && kick_fall &&
                !kick_is_early(i_window_mode, st_q.wd_cnt);
    fault_now = expired || early; // [R1] [R6] [R11]
  end

  always_comb begin
    st_d = st_q;
    st_d.lvl_s1 = i_supervised_level_in;
    st_d.lvl_s2 = st_q.lvl_s1;
    st_d.gate_s1 = i_gate_level_in;
    st_d.gate_s2 = st_q.gate_s1;
    st_d.fault = fault_now;

    // Reset hold timer. A new cause restarts the hold, so the pulse after
    // the last cause is always the full hold time.
    unique case (st_q.rst)
      svw_pkg::SVW_RS_RELEASED: begin
        if (!lvl_ok || fault_now) begin // [R8] [R10]
          st_d.rst = svw_pkg::SVW_RS_HOLD;
          st_d.hold_cnt = '0;
        end
      end
      svw_pkg::SVW_RS_HOLD: begin
        if (!lvl_ok) begin
          st_d.hold_cnt = '0; // [R9]
        end else if (st_q.hold_cnt == HOLD_LAST) begin // [R9] [R10]
          st_d.rst = svw_pkg::SVW_RS_RELEASED;
          st_d.hold_cnt = '0;
        end else begin
          st_d.hold_cnt = st_q.hold_cnt + CW'(1);
        end
      end
    endcase

    // Watchdog timer. Holding it at zero during reset also means that in
    // window mode timing starts from zero at release.
    if (!wd_run || kick_fall || expired) begin
      st_d.wd_cnt = '0; // [R2] [R7] [R11]
    end else begin
      st_d.wd_cnt = st_q.wd_cnt + CW'(1);
    end

    // Consecutive unkicked periods; any kick breaks the run.
    if (i_wdog_disable || kick_fall) begin
      st_d.miss_cnt = '0; // [R3] [R11]
    end else if (expired && st_q.miss_cnt != MISS_LAST) begin
      st_d.miss_cnt = st_q.miss_cnt + EW'(1);
    end

    unique case (st_q.take)
      svw_pkg::SVW_TK_CLEAR: begin
        st_d.good_cnt = '0;
        if (expired && st_q.miss_cnt == MISS_LAST &&
            lvl_ok && gate_ok) begin // [R3] [R5]
          st_d.take = svw_pkg::SVW_TK_ASSERTED;
        end
      end
      svw_pkg::SVW_TK_ASSERTED: begin
        if (fault_now) begin
          st_d.good_cnt = '0; // [R4]
        end else if (good_kick) begin
          if (st_q.good_cnt == GOOD_LAST) begin // [R4]
            st_d.take = svw_pkg::SVW_TK_CLEAR;
            st_d.good_cnt = '0;
            st_d.miss_cnt = '0;
          end else begin
            st_d.good_cnt = st_q.good_cnt + EW'(1);
          end
        end
      end
    endcase

    // A low level or a disabled watchdog drops takeover at once; the
    // output then cannot be low while either level reports low.
    if (!lvl_ok || !gate_ok || i_wdog_disable) begin
      st_d.take = svw_pkg::SVW_TK_CLEAR; // [R5] [R11]
      st_d.good_cnt = '0;
    end
  end

  // A reset lands in the hold state so the reset output is low at once.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q <= '{lvl_s1: 1'b0, lvl_s2: 1'b0, gate_s1: 1'b0, gate_s2: 1'b0,
                rst: svw_pkg::SVW_RS_HOLD, hold_cnt: '0, wd_cnt: '0,
                miss_cnt: '0, good_cnt: '0,
                take: svw_pkg::SVW_TK_CLEAR, fault: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reset_n = (st_q.rst == svw_pkg::SVW_RS_RELEASED); // [R16]
  assign o_takeover_n = (st_q.take == svw_pkg::SVW_TK_CLEAR); // [R16]
  assign o_wdog_fault = st_q.fault;

endmodule

// ===== bench/svw_core_asserts.sv
// Purpose: Port-level checks on the supervisor watchdog core.
// Assumes: One clock, synchronous active-low reset.
// Notes: Run-length counters stand in for long repetitions.
`timescale 1ns/100ps
module svw_core_asserts #(
  parameter longint unsigned HOLD_CYCLES = 10
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_supervised_level_in,
  input wire logic i_gate_level_in,
  input wire logic i_wdog_disable,
  input wire logic o_reset_n,
  input wire logic o_takeover_n,
  input wire logic o_wdog_fault
);
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  // The run counters restart in reset so they are never unknown at release.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hi_q <= 32'h0;
      lo_q <= 32'h0;
    end else begin
      hi_q <= i_supervised_level_in ? hi_q + 32'h1 : 32'h0;
      lo_q <= o_reset_n ? 32'h0 : lo_q + 32'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_flt_rst; o_wdog_fault |-> !o_reset_n; endproperty
  a_flt_rst: assert property (p_flt_rst) else $error("no reset");
  property p_flt_rel; o_wdog_fault |-> $past(o_reset_n); endproperty
  a_flt_rel: assert property (p_flt_rel) else $error("held");
  property p_dis; i_wdog_disable [*2] |-> !o_wdog_fault; endproperty
  a_dis: assert property (p_dis) else $error("disabled");
  property p_lvl_rst;
    !i_supervised_level_in [*3] |=> !o_reset_n;
  endproperty
  a_lvl_rst: assert property (p_lvl_rst) else $error("low lvl");
  property p_lvl_hold; $rose(o_reset_n) |-> hi_q >= HOLD_CYCLES; endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("lvl hold");
  property p_rst_hold; $rose(o_reset_n) |-> lo_q >= HOLD_CYCLES; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("short");
  // With the level high all along, the pulse is a watchdog pulse.
  property p_rst_exact;
    $rose(o_reset_n) && hi_q > lo_q |-> lo_q == HOLD_CYCLES;
  endproperty
  a_rst_exact: assert property (p_rst_exact) else $error("len");
  property p_take_lvl;
    (!i_supervised_level_in || !i_gate_level_in) [*3] |=> o_takeover_n;
  endproperty
  a_take_lvl: assert property (p_take_lvl) else $error("take");
  property p_take_fall; $fell(o_takeover_n) |-> o_wdog_fault; endproperty
  a_take_fall: assert property (p_take_fall) else $error("tk");
  c_flt: cover property (o_wdog_fault);
  c_take: cover property ($fell(o_takeover_n));
  c_free: cover property ($rose(o_takeover_n));
endmodule
bind svw_core svw_core_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst),
  .i_supervised_level_in(i_supervised_level_in),
  .i_gate_level_in(i_gate_level_in), .i_wdog_disable(i_wdog_disable),
  .o_reset_n(o_reset_n), .o_takeover_n(o_takeover_n),
  .o_wdog_fault(o_wdog_fault));

// ===== bench/svw_kick_host.sv
// Purpose: Controller model that kicks the watchdog pin.
// Assumes: Gap and low width in clock cycles, gap above low width.
// Notes: First fall comes gap minus low width cycles after start.
`timescale 1ns/100ps
module svw_kick_host (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [7:0] i_gap,
  input wire logic [7:0] i_low_w,
  output logic o_kick
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_run || cnt_q == i_gap - 8'h01)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  // The pin is always driven and idles high, never floating.
  assign o_kick = !(i_run && cnt_q >= i_gap - i_low_w);
endmodule

// ===== bench/svw_core_tb.sv
// Purpose: Self-checking bench for the supervisor core.
// Assumes: Period 40, hold 10 and filter 4 cycles.
// Notes: Kick falls reach the core late, so bounds have slack.
`timescale 1ns/100ps
module svw_core_tb;
  localparam int H = 10;
  logic i_clk, nr, lv, gt, win, dis, run, kick, rn, tn, flt;
  logic [7:0] gap, lw;
  int err_total, n_compared, cyc, k;
  svw_core #(.WD_CYCLES(40), .HOLD_CYCLES(H), .FILT_CYC(4)) dut (
    .i_clk(i_clk), .i_nrst(nr), .i_watchdog_kick_in(kick),
    .i_supervised_level_in(lv), .i_gate_level_in(gt),
    .i_window_mode(win), .i_wdog_disable(dis), .o_reset_n(rn),
    .o_takeover_n(tn), .o_wdog_fault(flt));
  svw_kick_host host (.i_clk(i_clk), .i_run(run), .i_gap(gap),
    .i_low_w(lw), .o_kick(kick));
  task automatic chk(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t check %0d", $time, n_compared);
    end
  endtask
  task automatic close_out;
    $display("compared %0d bad %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wait_rn(input logic v);
    k = 0;
    while (rn !== v && k < 300) begin
      tick(1);
      k++;
    end
  endtask
  task automatic miss3;
    for (int i = 0; i < 3; i++) begin
      chk(tn, 1'b1);
      wait_rn(0);
      chk(k > 35 && k < 45, 1'b1);
      chk(flt, 1'b1);
      wait_rn(1);
      chk(k == H, 1'b1);
      chk(flt, 1'b0);
    end
    chk(tn, 1'b0);
  endtask
  task automatic lvl_drop;
    lv = 0;
    gt = 0;
    tick(4);
    chk(rn, 1'b0);
    chk(tn, 1'b1);
    chk(flt, 1'b0);
    tick(20);
    chk(rn, 1'b0);
    lv = 1;
    gt = 1;
    wait_rn(1);
    chk(k >= H, 1'b1);
  endtask
  // Gate low alone drops takeover but not reset; the saturated miss
  // count then raises takeover again at the very next expiry.
  task automatic s_gate;
    gt = 0;
    tick(4);
    chk(tn, 1'b1);
    chk(rn, 1'b1);
    gt = 1;
    wait_rn(0);
    wait_rn(1);
    chk(tn, 1'b0);
  endtask
  task automatic s_reset;
    nr = 0;
    tick(3);
    chk(rn, 1'b0);
    chk(tn, 1'b1);
    chk(flt, 1'b0);
    nr = 1;
    wait_rn(1);
    chk(k == H + 2, 1'b1);
  endtask
  // A stopped host always ends in a fault, so each case starts fresh.
  task automatic s_kick(input logic w, input logic [7:0] g, l,
                        input logic e);
    logic seen;
    run = 0;
    wait_rn(0);
    wait_rn(1);
    win = w;
    gap = g;
    lw = l;
    run = 1;
    seen = 0;
    for (int i = 0; i < 150; i++) begin
      tick(1);
      seen |= !rn;
    end
    chk(seen, e);
  endtask
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    nr = 0;
    lv = 1;
    gt = 1;
    win = 0;
    dis = 0;
    run = 0;
    gap = 8'h1E;
    lw = 8'h08;
    tick(3);
    chk(tn, 1'b1);
    nr = 1;
    wait_rn(1);
    chk(k >= H && k <= H + 6, 1'b1);
    miss3();
    s_gate();
    run = 1;
    tick(40);
    chk(tn, 1'b0);
    tick(70);
    chk(tn, 1'b1);
    run = 0;
    lvl_drop();
    miss3();
    lvl_drop();
    s_kick(0, 8'h10, 8'h08, 0);
    s_kick(0, 8'h10, 8'h02, 1);
    s_reset();
    s_kick(0, 8'h32, 8'h08, 1);
    s_kick(1, 8'h10, 8'h08, 1);
    s_kick(1, 8'h32, 8'h08, 1);
    s_kick(1, 8'h1E, 8'h08, 0);
    dis = 1;
    run = 0;
    wait_rn(1);
    tick(150);
    chk(rn, 1'b1);
    chk(tn, 1'b1);
    close_out();
  end
endmodule
